// [rtl/esr_regs.vh]
`ifndef ESR_REGS_VH
`define ESR_REGS_VH
// Clock and time base
`define ESR_CLK_PERIOD_NS 8
`define ESR_TICK_US 1000
`define ESR_START_HOLD_US 500000
`define ESR_US_PER_S 1000000
`define ESR_NS_PER_US 1000
// Fixed point: reference held as 16.16 rpm
`define ESR_FRAC 16
// Percent quantities in 0.01 % units
`define ESR_PCT_FULL 16'h2710
`define ESR_PCT_SQ 32'h05F5_E100
// Analog input codes at the scaling endpoints
`define ESR_AIN_I_LO 16'h1000
`define ESR_AIN_I_HI 16'h5000
`define ESR_AIN_I_SHIFT 14
`define ESR_AIN_V_LO 16'h0800
`define ESR_AIN_V_HI 16'h2800
`define ESR_AIN_V_SHIFT 13
// Register word indexes (byte address = index * 4)
`define ESR_R_CTRL 6'h00
`define ESR_R_START 6'h01
`define ESR_R_UPPER 6'h02
`define ESR_R_LOWER 6'h03
`define ESR_R_IDLE 6'h04
`define ESR_R_RATED 6'h05
`define ESR_R_ACCEL_MS 6'h06
`define ESR_R_DECEL_MS 6'h07
`define ESR_R_RAISE_RATE 6'h08
`define ESR_R_LOWER_RATE 6'h09
`define ESR_R_DROOP 6'h0A
`define ESR_R_NO_LOAD 6'h0B
`define ESR_R_FULL_LOAD 6'h0C
`define ESR_R_RPM_CURVE 6'h0D
`define ESR_R_AUX_CURVE 6'h17
`define ESR_R_AIN_SCALE 6'h21
`define ESR_R_NUM_WR 6'h29
`define ESR_R_STATUS 6'h29
`define ESR_R_REF 6'h2A
`define ESR_R_FUEL 6'h2B
`define ESR_R_LOAD 6'h2C
// CTRL fields
`define ESR_CTRL_RPM_EN 0
`define ESR_CTRL_AUX_EN 1
`define ESR_CTRL_VOLT_LSB 4
// Analog channel numbers
`define ESR_AIN_SPARE1 0
`define ESR_AIN_SPARE2 1
`define ESR_AIN_REMOTE 2
`define ESR_AIN_AUX 3
`endif

// [rtl/esr_limiter.v]
`timescale 1ns/1ps
`default_nettype none
`include "esr_regs.vh"

module esr_curve (
  input wire [15:0] x_i,
  input wire [159:0] pts_i,
  output reg [15:0] y_o
);
  integer k;
  reg [15:0] xa;
  reg [15:0] xb;
  reg [15:0] ya;
  reg [15:0] yb;
  reg signed [33:0] prod;
  reg [16:0] dx;
  always @*
  begin
    xa = pts_i[15:0];
    ya = pts_i[31:16];
    xb = pts_i[15:0];
    yb = pts_i[31:16];
    prod = 34'sh0_0000_0000;
    dx = 17'h0_0001;
    // Points are x,y pairs with x ascending
    if (x_i <= pts_i[15:0])
      y_o = pts_i[31:16];
    else if (x_i >= pts_i[143:128])
      y_o = pts_i[159:144];
    else
    begin
      for (k = 3; k >= 0; k = k - 1)
        if (x_i < pts_i[k*32+32 +: 16])
        begin
          xa = pts_i[k*32 +: 16];
          ya = pts_i[k*32+16 +: 16];
          xb = pts_i[k*32+32 +: 16];
          yb = pts_i[k*32+48 +: 16];
        end
      dx = {1'b0, xb} - {1'b0, xa};
      if (dx == 17'h0_0000)
        dx = 17'h0_0001;
      prod = $signed({18'h0_0000, x_i - xa}) *
        ($signed({18'h0_0000, yb}) - $signed({18'h0_0000, ya}));
      prod = prod / $signed({17'h0_0000, dx});
      y_o = ya + prod[15:0];
    end
  end
endmodule

module esr_limiter #(
  parameter TICK_CYCLES = `ESR_TICK_US * `ESR_NS_PER_US / `ESR_CLK_PERIOD_NS
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [15:0] engine_speed_i,
  input wire rated_sel_i,
  input wire raise_i,
  input wire lower_i,
  input wire remote_en_i,
  input wire [15:0] ctrl_demand_i,
  input wire [15:0] ain_spare1_i,
  input wire [15:0] ain_spare2_i,
  input wire [15:0] ain_remote_i,
  input wire [15:0] ain_aux_i,
  output reg [15:0] speed_ref_o,
  output reg [15:0] fuel_demand_o,
  output reg [15:0] load_o,
  output reg [15:0] spare1_eu_o,
  output reg [15:0] spare2_eu_o,
  output reg running_o
);
  localparam ST_PRE = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam [31:0] TICKS_PER_S = `ESR_US_PER_S / `ESR_TICK_US;
  localparam [31:0] HOLD_TICKS = `ESR_START_HOLD_US / `ESR_TICK_US;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
  reg [15:0] cfg_q [0:`ESR_R_NUM_WR-1];
  reg [31:0] tick_cnt_q;
  reg tick_q;
  reg state_q;
  reg ramping_q;
  reg rated_q;
  reg [15:0] hold_q;
  reg [31:0] ref_q;
  reg [31:0] ref_d;
  integer i;
  wire [5:0] idx = wb_adr_i[7:2];
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [15:0] ctrl = cfg_q[`ESR_R_CTRL];
  wire [15:0] upper = cfg_q[`ESR_R_UPPER];
  wire [15:0] lower = cfg_q[`ESR_R_LOWER];
  wire [15:0] idle = cfg_q[`ESR_R_IDLE];
  wire [15:0] rated = cfg_q[`ESR_R_RATED];
  // Linear 4-20 mA or 1-5 V mapping to engineering units
  function [15:0] esr_scale;
    input [15:0] raw;
    input [15:0] lo;
    input [15:0] hi;
    input volt;
    reg [15:0] x0;
    reg [15:0] x1;
    reg [15:0] d;
    reg signed [33:0] p;
    begin
      x0 = volt ? `ESR_AIN_V_LO : `ESR_AIN_I_LO;
      x1 = volt ? `ESR_AIN_V_HI : `ESR_AIN_I_HI;
      if (raw < x0)
        d = 16'h0000;
      else if (raw > x1)
        d = x1 - x0;
      else
        d = raw - x0;
      p = $signed({18'h0_0000, d}) *
        ($signed({18'h0_0000, hi}) - $signed({18'h0_0000, lo}));
      p = volt ? (p >>> `ESR_AIN_V_SHIFT) : (p >>> `ESR_AIN_I_SHIFT);
      esr_scale = lo + p[15:0];
    end
  endfunction
  // Step toward a target, never past it
  function [31:0] esr_move;
    input [31:0] cur;
    input [31:0] tgt;
    input [31:0] up_step;
    input [31:0] dn_step;
    reg [32:0] s;
    begin
      if (tgt > cur)
      begin
        s = {1'b0, cur} + {1'b0, up_step};
        esr_move = (s >= {1'b0, tgt}) ? tgt : s[31:0];
      end
      else if ((cur - tgt) <= dn_step)
        esr_move = tgt;
      else
        esr_move = cur - dn_step;
    end
  endfunction
  // Ramp time in ms, one tick per ms; zero time means an immediate jump
  function [31:0] esr_ramp_step;
    input [15:0] span;
    input [15:0] ms;
    reg [31:0] s;
    begin
      s = {span, 16'h0000} / {16'h0000, ms};
      esr_ramp_step = (ms == 16'h0000 || s == 32'h0000_0000) ? 32'hFFFF_FFFF : s;
    end
  endfunction
  function [31:0] esr_rate_step;
    input [15:0] rate;
    reg [47:0] s;
    begin
      s = {16'h0000, rate, 16'h0000} / {16'h0000, TICKS_PER_S};
      esr_rate_step = s[31:0];
    end
  endfunction
  wire [15:0] ref_span = (rated > idle) ? rated - idle : 16'h0000;
  wire [31:0] accel_step = esr_ramp_step(ref_span, cfg_q[`ESR_R_ACCEL_MS]);
  wire [31:0] decel_step = esr_ramp_step(ref_span, cfg_q[`ESR_R_DECEL_MS]);
  wire [31:0] raise_step = esr_rate_step(cfg_q[`ESR_R_RAISE_RATE]);
  wire [31:0] lower_step = esr_rate_step(cfg_q[`ESR_R_LOWER_RATE]);
  wire [15:0] ramp_tgt = rated_sel_i ? rated : idle;
  wire [15:0] spare1_eu = esr_scale(ain_spare1_i, cfg_q[`ESR_R_AIN_SCALE],
    cfg_q[`ESR_R_AIN_SCALE+1], ctrl[`ESR_CTRL_VOLT_LSB+`ESR_AIN_SPARE1]);
  wire [15:0] spare2_eu = esr_scale(ain_spare2_i, cfg_q[`ESR_R_AIN_SCALE+2],
    cfg_q[`ESR_R_AIN_SCALE+3], ctrl[`ESR_CTRL_VOLT_LSB+`ESR_AIN_SPARE2]);
  wire [15:0] remote_rpm = esr_scale(ain_remote_i, cfg_q[`ESR_R_AIN_SCALE+4],
    cfg_q[`ESR_R_AIN_SCALE+5], ctrl[`ESR_CTRL_VOLT_LSB+`ESR_AIN_REMOTE]);
  wire [15:0] aux_eu = esr_scale(ain_aux_i, cfg_q[`ESR_R_AIN_SCALE+6],
    cfg_q[`ESR_R_AIN_SCALE+7], ctrl[`ESR_CTRL_VOLT_LSB+`ESR_AIN_AUX]);
  wire [15:0] remote_lim = (remote_rpm > upper) ? upper :
    (remote_rpm < lower) ? lower : remote_rpm;
  // Curve tables as flat x,y pairs
  wire [159:0] rpm_pts;
  wire [159:0] aux_pts;
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1)
    begin : g_pts
      assign rpm_pts[g*16 +: 16] = cfg_q[`ESR_R_RPM_CURVE+g];
      assign aux_pts[g*16 +: 16] = cfg_q[`ESR_R_AUX_CURVE+g];
    end
  endgenerate
  wire [15:0] rpm_limit;
  wire [15:0] aux_limit;
  esr_curve u_rpm_curve (
    .x_i(engine_speed_i),
    .pts_i(rpm_pts),
    .y_o(rpm_limit)
  );
  esr_curve u_aux_curve (
    .x_i(aux_eu),
    .pts_i(aux_pts),
    .y_o(aux_limit)
  );
  reg [15:0] fuel_d;
  always @*
  begin
    fuel_d = ctrl_demand_i;
    if (ctrl[`ESR_CTRL_RPM_EN] && rpm_limit < fuel_d)
      fuel_d = rpm_limit;
    if (ctrl[`ESR_CTRL_AUX_EN] && aux_limit < fuel_d)
      fuel_d = aux_limit;
  end
  // Internal load from the demand last sent to the actuator
  reg [15:0] load_d;
  reg [31:0] load_w;
  reg [63:0] drop_w;
  reg [15:0] out_ref_d;
  always @*
  begin
    load_w = 32'h0000_0000;
    if (cfg_q[`ESR_R_FULL_LOAD] <= cfg_q[`ESR_R_NO_LOAD] ||
        fuel_demand_o <= cfg_q[`ESR_R_NO_LOAD])
      load_d = 16'h0000;
    else
    begin
      load_w = ({16'h0000, fuel_demand_o - cfg_q[`ESR_R_NO_LOAD]} * {16'h0000, `ESR_PCT_FULL}) /
        {16'h0000, cfg_q[`ESR_R_FULL_LOAD] - cfg_q[`ESR_R_NO_LOAD]};
      load_d = (load_w > {16'h0000, `ESR_PCT_FULL}) ? `ESR_PCT_FULL : load_w[15:0];
    end
    drop_w = ({48'h0, ref_q[31:16]} * {48'h0, cfg_q[`ESR_R_DROOP]} * {48'h0, load_d}) /
      {32'h0000_0000, `ESR_PCT_SQ};
    if (cfg_q[`ESR_R_DROOP] == 16'h0000)
      out_ref_d = ref_q[31:16];
    else if (drop_w[15:0] >= ref_q[31:16] || drop_w[63:16] != 48'h0)
      out_ref_d = 16'h0000;
    else
      out_ref_d = ref_q[31:16] - drop_w[15:0];
  end
  // Reference sequencing, evaluated once per tick
  reg ramp_done;
  always @*
  begin
    ref_d = ref_q;
    ramp_done = 1'b0;
    if (state_q == ST_PRE)
      ref_d = {cfg_q[`ESR_R_START], 16'h0000};
    else if (ramping_q)
    begin
      // Rising uses accel time, falling decel time
      ref_d = esr_move(ref_q, {ramp_tgt, 16'h0000}, accel_step,
        decel_step);
      ramp_done = (ref_d == {ramp_tgt, 16'h0000});
    end
    else if (remote_en_i)
      ref_d = esr_move(ref_q, {remote_lim, 16'h0000}, raise_step,
        lower_step);
    else if (raise_i && !lower_i)
    begin
      ref_d = esr_move(ref_q, {upper, 16'h0000}, raise_step, 32'h0000_0000);
      if (ref_q >= {upper, 16'h0000})
        ref_d = {upper, 16'h0000};
    end
    else if (lower_i && !raise_i)
    begin
      ref_d = esr_move(ref_q, {lower, 16'h0000}, 32'h0000_0000, lower_step);
      if (ref_q <= {lower, 16'h0000})
        ref_d = {lower, 16'h0000};
    end
  end
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
      state_q <= ST_PRE;
      ramping_q <= 1'b0;
      rated_q <= 1'b0;
      hold_q <= 16'h0000;
      ref_q <= 32'h0000_0000;
      speed_ref_o <= 16'h0000;
      fuel_demand_o <= 16'h0000;
      load_o <= 16'h0000;
      spare1_eu_o <= 16'h0000;
      spare2_eu_o <= 16'h0000;
      running_o <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      rated_q <= rated_sel_i;
      if (state_q == ST_RUN && rated_sel_i != rated_q)
        ramping_q <= 1'b1;
      if (tick_q)
      begin
        ref_q <= ref_d;
        case (state_q)
          ST_PRE:
          begin
            if (engine_speed_i > cfg_q[`ESR_R_START])
              hold_q <= hold_q + 16'h0001;
            else
              hold_q <= 16'h0000;
            if (engine_speed_i > cfg_q[`ESR_R_START] &&
                {16'h0000, hold_q} + 32'h0000_0001 >= HOLD_TICKS)
            begin
              state_q <= ST_RUN;
              ramping_q <= 1'b1;
            end
          end
          ST_RUN:
          begin
            if (ramp_done && rated_sel_i == rated_q)
              ramping_q <= 1'b0;
            // Stopped engine re-arms the start sequence
            if (engine_speed_i == 16'h0000)
            begin
              state_q <= ST_PRE;
              ramping_q <= 1'b0;
              hold_q <= 16'h0000;
            end
          end
          default:
            state_q <= ST_PRE;
        endcase
      end
      speed_ref_o <= out_ref_d;
      fuel_demand_o <= fuel_d;
      load_o <= load_d;
      spare1_eu_o <= spare1_eu;
      spare2_eu_o <= spare2_eu;
      running_o <= (state_q == ST_RUN);
    end
  end
  // Wishbone classic slave, ack one cycle after the request
  reg [15:0] rd_d;
  always @*
  begin
    rd_d = 16'h0000;
    if (idx < `ESR_R_NUM_WR)
      rd_d = cfg_q[idx];
    else if (idx == `ESR_R_STATUS)
      rd_d = {14'h0000, ramping_q, state_q};
    else if (idx == `ESR_R_REF)
      rd_d = speed_ref_o;
    else if (idx == `ESR_R_FUEL)
      rd_d = fuel_demand_o;
    else if (idx == `ESR_R_LOAD)
      rd_d = load_o;
  end
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      for (i = 0; i < `ESR_R_NUM_WR; i = i + 1)
        cfg_q[i] <= 16'h0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req)
        wb_dat_o <= {16'h0000, rd_d};
      if (wb_req && wb_we_i && idx < `ESR_R_NUM_WR)
      begin
        if (wb_sel_i[0])
          cfg_q[idx][7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          cfg_q[idx][15:8] <= wb_dat_i[15:8];
      end
    end
  end
endmodule
`default_nettype wire

// [bench/esr_props.sv]
`timescale 1ns/1ps
`default_nettype none
module esr_props #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [15:0] engine_speed_i,
  input wire logic [15:0] ctrl_demand_i,
  input wire logic [15:0] fuel_demand_o,
  input wire logic running_o
);
  localparam int HOLD = 499 * TICK_CYCLES;
  localparam int DROP = 2 * TICK_CYCLES + 2;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] spin_q;
  // Cycles in a row with the engine turning
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      spin_q <= 32'h0000_0000;
    else if (engine_speed_i == 16'h0000)
      spin_q <= 32'h0000_0000;
    else
      spin_q <= spin_q + 32'h0000_0001;
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_next: assert property (s_req |=> s_ans)
    else $error("ack not a single pulse after request");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack not caused by request");
  a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_fuel_below_ctrl: assert property (fuel_demand_o <= $past(ctrl_demand_i))
    else $error("fuel demand above controller demand");
  a_run_after_hold: assert property ($rose(running_o) |-> spin_q >= HOLD)
    else $error("run started before hold time");
  a_run_stays_off: assert property (!running_o && !(|engine_speed_i) |=> !running_o)
    else $error("run started with engine stopped");
  a_run_drop_stop: assert property (running_o && engine_speed_i == 16'h0000 |-> ##[1:DROP] !running_o)
    else $error("run kept with engine stopped");
endmodule
bind esr_limiter esr_props #(.TICK_CYCLES(TICK_CYCLES)) u_esr_props (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .engine_speed_i(engine_speed_i),
  .ctrl_demand_i(ctrl_demand_i), .fuel_demand_o(fuel_demand_o), .running_o(running_o));
`default_nettype wire

// [bench/esr_engine_model.sv]
`timescale 1ns/1ps
`default_nettype none
module esr_engine_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] tgt_i,
  input wire logic slow_i,
  output logic [15:0] speed_o
);
  // Slow mode moves one rpm per cycle, as inertia would
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      speed_o <= 16'h0000;
    else if (!slow_i || speed_o == tgt_i)
      speed_o <= tgt_i;
    else if (speed_o < tgt_i)
      speed_o <= speed_o + 16'h0001;
    else
      speed_o <= speed_o - 16'h0001;
endmodule
`default_nettype wire

// [bench/esr_limiter_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module esr_limiter_tb;
  localparam int TK = 10;
  typedef struct packed {logic [15:0] e; logic [15:0] t;} esr_exp_t;
  logic clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, we = 1'h0, pr = 1'h0;
  logic rated = 1'h0, rai = 1'h0, low = 1'h0, rem = 1'h0, slow = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h3;
  logic [31:0] dat = 32'h0000_0000, lf = 32'h0000_3369;
  logic [15:0] ctrl = 16'h0000, tgt = 16'h0000, pv = 16'h0000, got, d, fx;
  logic [15:0] ain [4] = '{16'h1000, 16'h1000, 16'h1000, 16'h1000};
  logic [15:0] cv [1:12] = '{16'h0064, 16'h028a, 16'h00fa, 16'h012c, 16'h0258, 16'h0064,
    16'h0064, 16'h03e8, 16'h03e8, 16'h0000, 16'h0000, 16'h2710};
  logic [15:0] sc [8] = '{16'h0064, 16'h01f4, 16'h0000, 16'h03e8, 16'h00c8, 16'h0258,
    16'h0000, 16'h03e8};
  logic [15:0] cw [8] = '{16'h0021, 16'h0021, 16'h0021, 16'h0022, 16'h00a2, 16'h0022,
    16'h0020, 16'h0023};
  logic [15:0] ft [8] = '{16'h0032, 16'h00fa, 16'h0258, 16'h0258, 16'h0258, 16'h0258,
    16'h0032, 16'h00fa};
  logic [15:0] fa [8] = '{16'h1000, 16'h1000, 16'h1000, 16'h3000, 16'h1800, 16'h5000,
    16'h5000, 16'h3000};
  logic [15:0] fe [8] = '{16'h03e8, 16'h09c4, 16'h1388, 16'h0bb8, 16'h0bb8, 16'h03e8,
    16'hffff, 16'h09c4};
  wire [31:0] rdat;
  wire [15:0] speed, sref, fuel, load, sp1, sp2;
  wire ack, run;
  esr_exp_t q[$], x;
  int checks = 0, n_errors = 0;
  always #4 clk = ~clk;
  esr_engine_model u_esr_engine_model (.mclk_i(clk), .rst_n_i(rst_n), .tgt_i(tgt),
    .slow_i(slow), .speed_o(speed));
  esr_limiter #(.TICK_CYCLES(TK)) u_esr_limiter (.mclk_i(clk), .rst_n_i(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .engine_speed_i(speed),
    .rated_sel_i(rated), .raise_i(rai), .lower_i(low), .remote_en_i(rem),
    .ctrl_demand_i(ctrl), .ain_spare1_i(ain[0]), .ain_spare2_i(ain[1]),
    .ain_remote_i(ain[2]), .ain_aux_i(ain[3]), .speed_ref_o(sref), .fuel_demand_o(fuel),
    .load_o(load), .spare1_eu_o(sp1), .spare2_eu_o(sp2), .running_o(run));
  // Compares each read or probe against the oldest expectation
  always @(posedge clk)
  begin
    if ((ack === 1'h1 && !we) || pr)
    begin
      got = pr ? pv : rdat[15:0];
      x = q.pop_front();
      d = got > x.e ? got - x.e : x.e - got;
      checks++;
      if ((^got) === 1'hx || d > x.t)
      begin
        n_errors++;
        $display("ERROR %0t got %0d expected %0d", $time, got, x.e);
      end
    end
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wb(input logic w, input logic [5:0] i, input logic [15:0] v);
    int n = 0;
    begin
      cyc <= 1'h1;
      we <= w;
      adr <= {i, 2'h0};
      dat <= {16'h0000, v};
      do
      begin
        @(posedge clk);
        n++;
      end
      while (ack !== 1'h1 && n < 50);
      cyc <= 1'h0;
      we <= 1'h0;
      if (n >= 50)
      begin
        n_errors++;
        $display("ERROR %0t bus request not answered", $time);
      end
      @(posedge clk);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] v);
    wb(1'h1, i, v);
  endtask
  task automatic rd(input logic [5:0] i, input logic [15:0] e);
    q.push_back({e, 16'h0000});
    wb(1'h0, i, 16'h0000);
  endtask
  task automatic chk(input logic [15:0] v, input logic [15:0] e, input logic [15:0] t);
    q.push_back({e, t});
    pv <= v;
    pr <= 1'h1;
    @(posedge clk);
    pr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic tk(input int n);
    repeat (n * TK) @(posedge clk);
  endtask
  task automatic sp(input int n, input logic [15:0] e, input logic [15:0] t);
    tk(n);
    chk(sref, e, t);
  endtask
  task give_verdict;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(6'h00, 16'h0000);
    rd(6'h29, 16'h0000);
    rd(6'h3f, 16'h0000);
    wr(6'h2a, 16'h1234);
    rd(6'h2a, 16'h0000);
    for (int i = 1; i <= 12; i++)
      wr(6'(i), cv[i]);
    for (int i = 0; i < 5; i++)
    begin
      wr(6'(13 + 2 * i), 16'h0064 * 16'(i + 1));
      wr(6'(14 + 2 * i), 16'h03e8 * 16'(i + 1));
      wr(6'(23 + 2 * i), 16'h00fa * 16'(i));
      wr(6'(24 + 2 * i), 16'h1388 - 16'h03e8 * 16'(i));
    end
    for (int i = 0; i < 8; i++)
      wr(6'(33 + i), sc[i]);
    rd(6'h04, 16'h012c);
    // Byte lane 1 only: low byte must keep its value
    sel <= 4'h2;
    wr(6'h04, 16'hab00);
    rd(6'h04, 16'hab2c);
    sel <= 4'h3;
    wr(6'h04, 16'h012c);
    sp(2, 16'h0064, 16'h0000);
    slow <= 1'h1;
    tgt <= 16'h00c8;
    tk(450);
    chk({15'h0000, run}, 16'h0000, 16'h0000);
    tk(80);
    chk({15'h0000, run}, 16'h0001, 16'h0000);
    sp(100, 16'h012c, 16'h0000);
    rated <= 1'h1;
    sp(40, 16'h01a4, 16'h0006);
    sp(80, 16'h0258, 16'h0000);
    rated <= 1'h0;
    sp(40, 16'h01e0, 16'h0006);
    sp(80, 16'h012c, 16'h0000);
    rated <= 1'h1;
    tk(110);
    rai <= 1'h1;
    sp(20, 16'h026c, 16'h0002);
    sp(60, 16'h028a, 16'h0000);
    rai <= 1'h0;
    low <= 1'h1;
    sp(450, 16'h00fa, 16'h0000);
    low <= 1'h0;
    ain[2] <= 16'h3000;
    rem <= 1'h1;
    sp(50, 16'h012c, 16'h0003);
    sp(150, 16'h0190, 16'h0000);
    ain[2] <= 16'h1000;
    sp(50, 16'h015e, 16'h0003);
    sp(150, 16'h00fa, 16'h0000);
    rem <= 1'h0;
    ain[0] <= 16'h3000;
    ain[1] <= 16'h1800;
    wr(6'h00, 16'h0020);
    tk(1);
    chk(sp1, 16'h012c, 16'h0000);
    chk(sp2, 16'h01f4, 16'h0000);
    slow <= 1'h0;
    for (int k = 0; k < 8; k++)
    begin
      lf = nx(lf);
      wr(6'h00, cw[k]);
      ctrl <= 16'h1f40 + {6'h00, lf[9:0]};
      tgt <= ft[k];
      ain[3] <= fa[k];
      tk(1);
      fx = (fe[k] == 16'hffff) ? ctrl : fe[k];
      chk(fuel, fx, 16'h0000);
    end
    wr(6'h00, 16'h0020);
    ctrl <= 16'h1388;
    wr(6'h0a, 16'h03e8);
    tk(3);
    chk(load, 16'h1388, 16'h0000);
    chk(sref, 16'h00ed, 16'h0001);
    tgt <= 16'h0000;
    tk(3);
    chk({15'h0000, run}, 16'h0000, 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire
